// ### exc_pkg.sv
// Package of constants and carriers for the exception generation block.
package exc_pkg;
   // ---------------------------------------------------------------
   // Vectors and widths.
   // ---------------------------------------------------------------
   localparam logic [7:0]  VEC_FLOAT = 8'h10;     // Float error fault.
   localparam logic [7:0]  VEC_ALIGN = 8'h11;     // Alignment fault.
   localparam logic [7:0]  VEC_MCHK  = 8'h12;     // Machine check abort.
   localparam logic [31:0] ERR_ZERO  = 32'h0000_0000; // Alignment code.
   localparam logic [1:0]  PRIV_USER = 2'h3;      // User privilege level.
   localparam int          FLAG_W    = 6;         // Float error flags.
   // Low address bits that must be clear for divisors two, four and eight.
   localparam logic [2:0]  LOW_MASK2 = 3'h1;      // Divisor two.
   localparam logic [2:0]  LOW_MASK4 = 3'h3;      // Divisor four.
   localparam logic [2:0]  LOW_MASK8 = 3'h7;      // Divisor eight.

   // Operand classes, each mapping to an alignment divisor.
   typedef enum logic [3:0] {
      OP_BYTE, OP_WORD, OP_DWORD, OP_SREAL, OP_DREAL, OP_XREAL, OP_SELECTOR,
      OP_FAR32, OP_FAR48, OP_PTR32, OP_TABLEREG, OP_ENVAREA, OP_FULLSAVE,
      OP_BITSTR
   } opclass_e;

   // Float instruction kinds seen at issue.
   typedef enum logic [1:0] {
      FI_NONE, FI_WAITING, FI_NOWAIT, FI_WAITINSN
   } fkind_e;

   // Memory reference presented for checking.
   typedef struct packed {
      logic        valid;      // Reference in this cycle.
      logic [31:0] addr;       // Linear address.
      opclass_e    opClass;    // Data type of operand.
      logic        opSize32;   // Current operand size is 32 bits.
      logic        dataSeg;    // Data or stack segment.
      logic        implicitSys;// Implicit privilege zero reference.
   } memref_s;

   // Request to the dispatch path.
   typedef struct packed {
      logic [7:0]  vector;
      logic        codeValid;
      logic [31:0] code;
      logic [47:0] savedPtr;   // Selector and pointer.
      logic        isAbort;
   } excreq_s;
endpackage : exc_pkg

// ### align_check.sv
// Alignment checker for one memory reference.
`timescale 1ns/1ns
module align_check (
   input  wire exc_pkg::memref_s ref_i,
   input  wire logic             alignMask,
   input  wire logic             alignFlag,
   input  wire logic [1:0]       currentPrivilegeLevel,
   output logic                  misaligned
);
   logic [2:0] lowMask;    // Address bits that must be zero.
   logic       enabled;    // Checking enabled in this cycle.

   // ---------------------------------------------------------------
   // Divisor per type, then the gated check.
   // ---------------------------------------------------------------
   always_comb begin
      case (ref_i.opClass)
         exc_pkg::OP_WORD, exc_pkg::OP_SELECTOR, exc_pkg::OP_FAR32:
            lowMask = exc_pkg::LOW_MASK2;
         exc_pkg::OP_DWORD, exc_pkg::OP_SREAL, exc_pkg::OP_PTR32,
         exc_pkg::OP_FAR48, exc_pkg::OP_TABLEREG:
            lowMask = exc_pkg::LOW_MASK4;
         exc_pkg::OP_DREAL, exc_pkg::OP_XREAL:
            lowMask = exc_pkg::LOW_MASK8;
         exc_pkg::OP_ENVAREA, exc_pkg::OP_FULLSAVE, exc_pkg::OP_BITSTR:
            lowMask = ref_i.opSize32 ? exc_pkg::LOW_MASK4
                                     : exc_pkg::LOW_MASK2;
         default:
            lowMask = '0; // Bytes are always aligned.
      endcase
      // Both enables together, user level only.
      enabled = alignMask && alignFlag
                && (currentPrivilegeLevel == exc_pkg::PRIV_USER);
      // Implicit system references and code segments are exempt.
      misaligned = ref_i.valid && enabled && ref_i.dataSeg
                   && !ref_i.implicitSys
                   && ((ref_i.addr[2:0] & lowMask) != '0);
   end
endmodule : align_check

// ### float_pending.sv
// Pending float error tracker with recorded faulting pointer.
`timescale 1ns/1ns
module float_pending (
   input  wire logic                       clock,
   input  wire logic                       srst,
   input  wire logic                       fpError,
   input  wire logic [exc_pkg::FLAG_W-1:0] fpErrFlags,
   input  wire logic [exc_pkg::FLAG_W-1:0] fpErrMask,
   input  wire logic [47:0]                fpErrPtr,
   input  wire logic                       numericErrorEnable,
   input  wire logic                       takeFloat,
   input  wire logic                       fpStateClear,
   output logic                            pending,
   output logic [exc_pkg::FLAG_W-1:0]      statusFlags,
   output logic [47:0]                     fpuInstrPtr
);
   logic                       pending_q, pending_d;
   logic [exc_pkg::FLAG_W-1:0] status_q, status_d;
   logic [47:0]                ptr_q, ptr_d;
   logic                       unmasked;

   // ---------------------------------------------------------------
   // Status flags always record; pending only for unmasked errors.
   // ---------------------------------------------------------------
   always_comb begin
      unmasked  = fpError && ((fpErrFlags & ~fpErrMask) != '0);
      status_d  = fpStateClear ? '0 : status_q;
      ptr_d     = ptr_q;
      pending_d = pending_q;
      if (takeFloat || fpStateClear) begin
         pending_d = 1'b0;
      end
      if (fpError) begin
         status_d = status_d | fpErrFlags;
         ptr_d    = fpErrPtr;
      end
      // A new error wins over a clear in the same cycle.
      if (unmasked && numericErrorEnable) begin
         pending_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pending_q <= 1'b0;
         status_q  <= '0;
         ptr_q     <= 48'h0000_0000_0000;
      end else begin
         pending_q <= pending_d;
         status_q  <= status_d;
         ptr_q     <= ptr_d;
      end
   end

   assign pending     = pending_q;
   assign statusFlags = status_q;
   assign fpuInstrPtr = ptr_q;

   pend_set_a: assert property (@(posedge clock) disable iff (srst)
      fpError && numericErrorEnable && ((fpErrFlags & ~fpErrMask) != '0)
      |=> pending_q) else $error("Unmasked error not pending.");
   ptr_keep_a: assert property (@(posedge clock) disable iff (srst)
      fpError |=> ptr_q == $past(fpErrPtr)) else $error("Pointer lost.");
endmodule : float_pending

// ### exception_unit.sv
// Exception generation for float error, alignment and machine check.
`timescale 1ns/1ns
module exception_unit (
   input  wire logic                       clock,
   input  wire logic                       srst,
   // Control state from the core registers.
   input  wire logic                       numericErrorEnable,
   input  wire logic                       alignMaskEnable,
   input  wire logic                       alignCheckFlag,
   input  wire logic [1:0]                 currentPrivilegeLevel,
   input  wire logic                       machineCheckEnable,
   // Float unit error reports.
   input  wire logic                       fpError,
   input  wire logic [exc_pkg::FLAG_W-1:0] fpErrFlags,
   input  wire logic [exc_pkg::FLAG_W-1:0] fpErrMask,
   input  wire logic [47:0]                fpErrPtr,
   input  wire logic                       fpStateClear,
   // Instruction at issue.
   input  wire logic                       issueValid,
   input  wire exc_pkg::fkind_e            issueKind,
   input  wire logic [47:0]                issuePtr,
   input  wire exc_pkg::memref_s           memRef,
   // Machine error report.
   input  wire logic                       machineError,
   input  wire logic                       machineErrPtrTied,
   input  wire logic [47:0]                machineErrPtr,
   // Dispatch handshake.
   input  wire logic                       dispatchReady,
   output logic                            dispatchValid,
   output exc_pkg::excreq_s                dispatchReq,
   output logic                            issueStall,
   output logic                            issueSuppress,
   output logic                            shutdown,
   output logic                            savedPointerValid,
   output logic [exc_pkg::FLAG_W-1:0]      fpuStatusFlags,
   output logic [47:0]                     fpuInstrPtr
);
   // ---------------------------------------------------------------
   // States of the dispatch engine.
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_DEAD} state_e;

   state_e           state_q, state_d;    // Engine state.
   exc_pkg::excreq_s req_q, req_d;        // Held request.
   logic             saved_pointer_valid_q, saved_pointer_valid_d;      // Saved pointer valid flag.
   logic             shut_q, shut_d;      // Shutdown latch.
   logic             fpPending;           // Float error outstanding.
   logic             misaligned;          // Current reference is bad.
   logic             waitingInsn;         // Instruction checks pending.
   logic             takeFloat;           // Float error taken now.
   logic             takeAlign;           // Alignment fault taken now.
   logic             takeMchk;            // Machine check taken now.

   // ---------------------------------------------------------------
   // Helpers.
   // ---------------------------------------------------------------
   float_pending u_pend (
      .clock              (clock),
      .srst               (srst),
      .fpError            (fpError),
      .fpErrFlags         (fpErrFlags),
      .fpErrMask          (fpErrMask),
      .fpErrPtr           (fpErrPtr),
      .numericErrorEnable (numericErrorEnable),
      .takeFloat          (takeFloat),
      .fpStateClear       (fpStateClear),
      .pending            (fpPending),
      .statusFlags        (fpuStatusFlags),
      .fpuInstrPtr        (fpuInstrPtr)
   );

   align_check u_align (
      .ref_i                 (memRef),
      .alignMask             (alignMaskEnable),
      .alignFlag             (alignCheckFlag),
      .currentPrivilegeLevel (currentPrivilegeLevel),
      .misaligned            (misaligned)
   );

   // ---------------------------------------------------------------
   // Event selection. Machine check ranks first, then the float
   // error at a waiting instruction, then alignment. Only one event
   // is accepted while idle; the pipeline is held until it leaves.
   // ---------------------------------------------------------------
   always_comb begin
      // No-wait forms skip the pending check.
      waitingInsn = issueValid && ((issueKind == exc_pkg::FI_WAITING)
                    || (issueKind == exc_pkg::FI_WAITINSN));
      takeMchk  = (state_q == ST_IDLE) && machineError;
      takeFloat = (state_q == ST_IDLE) && !machineError && numericErrorEnable
                  && waitingInsn && fpPending;
      takeAlign = (state_q == ST_IDLE) && !machineError && !takeFloat
                  && misaligned;
   end

   // ---------------------------------------------------------------
   // Next state and request content.
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      req_d   = req_q;
      saved_pointer_valid_d  = saved_pointer_valid_q;
      shut_d  = shut_q;
      case (state_q)
         ST_IDLE: begin
            if (takeMchk) begin
               saved_pointer_valid_d = machineErrPtrTied;
               if (machineCheckEnable) begin
                  req_d.vector    = exc_pkg::VEC_MCHK;
                  req_d.codeValid = 1'b0;
                  req_d.code      = exc_pkg::ERR_ZERO;
                  req_d.savedPtr  = machineErrPtr;
                  req_d.isAbort   = 1'b1;
                  state_d         = ST_REQ;
               end else begin
                  shut_d  = 1'b1;
                  state_d = ST_DEAD;
               end
            end else if (takeFloat) begin
               req_d.vector    = exc_pkg::VEC_FLOAT;
               req_d.codeValid = 1'b0;
               req_d.code      = exc_pkg::ERR_ZERO;
               req_d.savedPtr  = issuePtr;
               req_d.isAbort   = 1'b0;
               state_d         = ST_REQ;
            end else if (takeAlign) begin
               req_d.vector    = exc_pkg::VEC_ALIGN;
               req_d.codeValid = 1'b1;
               req_d.code      = exc_pkg::ERR_ZERO;
               req_d.savedPtr  = issuePtr;
               req_d.isAbort   = 1'b0;
               state_d         = ST_REQ;
            end
         end
         ST_REQ: begin
            // Request held stable until the dispatch path accepts it.
            if (dispatchReady) begin
               state_d = req_q.isAbort ? ST_DEAD : ST_IDLE;
            end
         end
         ST_DEAD: begin
            // After an abort or shutdown only reset resumes execution.
            state_d = ST_DEAD;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= ST_IDLE;
         req_q   <= '0;
         saved_pointer_valid_q  <= 1'b0;
         shut_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         req_q   <= req_d;
         saved_pointer_valid_q  <= saved_pointer_valid_d;
         shut_q  <= shut_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs. Suppress kills the issuing instruction in the cycle its
   // fault is taken so it leaves no state behind and can restart.
   // ---------------------------------------------------------------
   assign dispatchValid     = (state_q == ST_REQ);
   assign dispatchReq       = req_q;
   assign issueSuppress     = takeFloat || takeAlign || takeMchk;
   assign issueStall        = (state_q != ST_IDLE);
   assign shutdown          = shut_q;
   assign savedPointerValid = saved_pointer_valid_q;

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   float_vec_a: assert property (@(posedge clock) disable iff (srst)
      takeFloat |=> dispatchValid && dispatchReq.vector == exc_pkg::VEC_FLOAT
      && !dispatchReq.codeValid && dispatchReq.savedPtr == $past(issuePtr))
      else $error("Float error request wrong.");
   // A no-wait form must never turn into a float error request.
   float_gate_a: assert property (@(posedge clock) disable iff (srst)
      state_q == ST_IDLE && issueValid && issueKind == exc_pkg::FI_NOWAIT
      |=> !(dispatchValid && dispatchReq.vector == exc_pkg::VEC_FLOAT))
      else $error("Float error at no-wait instruction.");
   align_req_a: assert property (@(posedge clock) disable iff (srst)
      takeAlign |=> dispatchReq.vector == exc_pkg::VEC_ALIGN
      && dispatchReq.codeValid && dispatchReq.code == exc_pkg::ERR_ZERO)
      else $error("Alignment request wrong.");
   align_priv_a: assert property (@(posedge clock) disable iff (srst)
      takeAlign |-> currentPrivilegeLevel == exc_pkg::PRIV_USER
      && alignMaskEnable && alignCheckFlag && !memRef.implicitSys)
      else $error("Alignment fault while disabled.");
   align_supp_a: assert property (@(posedge clock) disable iff (srst)
      takeAlign |-> issueSuppress) else $error("Faulting op not suppressed.");
   mchk_abort_a: assert property (@(posedge clock) disable iff (srst)
      takeMchk && machineCheckEnable |=> dispatchValid
      && dispatchReq.vector == exc_pkg::VEC_MCHK && dispatchReq.isAbort
      && !dispatchReq.codeValid) else $error("Machine check request wrong.");
   mchk_shut_a: assert property (@(posedge clock) disable iff (srst)
      takeMchk && !machineCheckEnable |=> shutdown && !dispatchValid [*3])
      else $error("No shutdown on disabled machine check.");
   saved_pointer_valid_flag_a: assert property (@(posedge clock) disable iff (srst)
      takeMchk |=> savedPointerValid == $past(machineErrPtrTied))
      else $error("Saved pointer flag wrong.");
   req_hold_a: assert property (@(posedge clock) disable iff (srst)
      dispatchValid && !dispatchReady |=> dispatchValid && $stable(dispatchReq))
      else $error("Request dropped before accept.");

   float_cov: cover property (@(posedge clock) disable iff (srst) takeFloat);
   align_cov: cover property (@(posedge clock) disable iff (srst) takeAlign);
   mchk_cov:  cover property (@(posedge clock) disable iff (srst)
      takeMchk && machineCheckEnable);
   shut_cov:  cover property (@(posedge clock) disable iff (srst)
      takeMchk && !machineCheckEnable);
endmodule : exception_unit

// ### pipe_model.sv
// Behavioural issue stage and float unit that feed the exception block.
`timescale 1ns/1ns
module pipe_model (
   input  wire logic                       clock,
   output exc_pkg::fkind_e                 issueKind,
   output logic                            issueValid,
   output logic [47:0]                     issuePtr,
   output exc_pkg::memref_s                memRef,
   output logic                            fpError,
   output logic [exc_pkg::FLAG_W-1:0]      fpErrFlags,
   output logic [exc_pkg::FLAG_W-1:0]      fpErrMask,
   output logic [47:0]                     fpErrPtr
);
   // ------------------------------------------------------------
   // Idle values at time zero.
   // ------------------------------------------------------------
   initial begin
      issueKind = exc_pkg::FI_NONE;
      issueValid = 1'b0;
      issuePtr = 48'h0;
      memRef = '0;
      fpError = 1'b0;
      fpErrFlags = '0;
      fpErrMask = '0;
      fpErrPtr = 48'h0;
   end

   // Present one instruction; the caller has just seen a rising edge.
   task automatic present(input exc_pkg::fkind_e k, input logic [47:0] p,
                          input exc_pkg::memref_s r);
      issueValid <= 1'b1;
      issueKind <= k;
      issuePtr <= p;
      memRef <= r;
   endtask : present

   // Withdraw it; qualifiers are scrambled so stale values never match.
   task automatic retire();
      exc_pkg::memref_s r;
      r = ~memRef;
      r.valid = 1'b0;
      issueValid <= 1'b0;
      issueKind <= exc_pkg::FI_NONE;
      issuePtr <= ~issuePtr;
      memRef <= r;
   endtask : retire

   // One-cycle error report from the float unit.
   task automatic report(input logic [5:0] f, input logic [5:0] m, input logic [47:0] p);
      @(posedge clock);
      fpError <= 1'b1;
      fpErrFlags <= f;
      fpErrMask <= m;
      fpErrPtr <= p;
      @(posedge clock);
      fpError <= 1'b0;
      fpErrFlags <= ~f;
      fpErrPtr <= ~p;
   endtask : report
endmodule : pipe_model

// ### exception_unit_tb.sv
// Self-checking bench for the exception generation block.
`timescale 1ns/1ns
module exception_unit_tb;
   // ------------------------------------------------------------
   // Signals and counters.
   // ------------------------------------------------------------
   logic clock, srst, numericErrorEnable, alignMaskEnable, alignCheckFlag;
   logic machineCheckEnable, fpStateClear, machineError, machineErrPtrTied;
   logic dispatchReady, issueValid, fpError, dispatchValid, issueStall;
   logic issueSuppress, shutdown, savedPointerValid;
   logic [1:0]  currentPrivilegeLevel;
   logic [47:0] machineErrPtr, issuePtr, fpErrPtr, fpuInstrPtr, ptr;
   logic [5:0]  fpErrFlags, fpErrMask, fpuStatusFlags;
   exc_pkg::fkind_e  issueKind;
   exc_pkg::memref_s memRef, r;
   exc_pkg::excreq_s dispatchReq, fexp, aexp;
   int failures, n_checks, d;

   exception_unit i_dut (.clock, .srst, .numericErrorEnable, .alignMaskEnable,
      .alignCheckFlag, .currentPrivilegeLevel, .machineCheckEnable, .fpError,
      .fpErrFlags, .fpErrMask, .fpErrPtr, .fpStateClear, .issueValid, .issueKind,
      .issuePtr, .memRef, .machineError, .machineErrPtrTied, .machineErrPtr,
      .dispatchReady, .dispatchValid, .dispatchReq, .issueStall, .issueSuppress,
      .shutdown, .savedPointerValid, .fpuStatusFlags, .fpuInstrPtr);
   pipe_model i_pipe (.clock, .issueKind, .issueValid, .issuePtr, .memRef,
      .fpError, .fpErrFlags, .fpErrMask, .fpErrPtr);

   // ------------------------------------------------------------
   // Clock, watchdog and verdict.
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // The tests need well under a thousand cycles; ten thousand means a hang.
   initial begin
      #100_000;
      failures++;
      end_of_test();
   end

   task automatic end_of_test();
      if (failures == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // ------------------------------------------------------------
   // Compare tasks and helpers.
   // ------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chk

   // Every request, an abort too, carries the pointer that the core saved.
   task automatic chkReq(input exc_pkg::excreq_s e);
      n_checks++;
      if ({dispatchReq.vector, dispatchReq.codeValid, dispatchReq.isAbort} !==
          {e.vector, e.codeValid, e.isAbort} ||
          dispatchReq.savedPtr !== e.savedPtr ||
          (e.codeValid && dispatchReq.code !== e.code)) begin
         failures++;
         $display("ERROR %0t dispatch request fields differ", $time);
      end
   endtask : chkReq

   function automatic exc_pkg::excreq_s mk(input logic [7:0] v, input logic cv,
                                           input logic ab);
      return '{vector: v, codeValid: cv, code: exc_pkg::ERR_ZERO, savedPtr: 48'h0,
               isAbort: ab};
   endfunction : mk

   function automatic exc_pkg::memref_s mref(input exc_pkg::opclass_e c,
                                             input logic s, input logic [31:0] a);
      return '{valid: 1'b1, addr: a, opClass: c, opSize32: s, dataSeg: 1'b1,
               implicitSys: 1'b0};
   endfunction : mref

   // Required address divisor of each operand class except OP_BYTE, which gets 4.
   function automatic int div(input exc_pkg::opclass_e c, input logic s);
      case (c)
         exc_pkg::OP_WORD, exc_pkg::OP_SELECTOR, exc_pkg::OP_FAR32: return 2;
         exc_pkg::OP_DREAL, exc_pkg::OP_XREAL: return 8;
         exc_pkg::OP_ENVAREA, exc_pkg::OP_FULLSAVE, exc_pkg::OP_BITSTR: return s ? 4 : 2;
         default: return 4;
      endcase
   endfunction : div

   // One instruction through issue; a low ready checks that the request stands.
   task automatic run(input exc_pkg::fkind_e k, input exc_pkg::memref_s m,
                      input logic ex, input exc_pkg::excreq_s e);
      int n;
      ptr = ptr + 48'h0000_0000_0104;
      e.savedPtr = ptr;
      @(posedge clock);
      i_pipe.present(k, ptr, m);
      #1 chk(64'(issueSuppress), 64'(ex), "suppress");
      @(posedge clock);
      i_pipe.retire();
      #1 chk(64'(dispatchValid), 64'(ex), "request");
      if (ex) chkReq(e);
      if (ex && dispatchReady !== 1'b1) begin
         repeat (3) @(posedge clock);
         #1 chk(64'(dispatchValid), 64'h1, "held");
         chkReq(e);
         @(posedge clock);
         dispatchReady <= 1'b1;
      end
      n = 0;
      while (issueStall === 1'b1 && n < 20) begin
         @(posedge clock);
         n++;
      end
   endtask : run

   task automatic doReset();
      @(posedge clock);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
   endtask : doReset

   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial begin
      {srst, numericErrorEnable, alignMaskEnable, alignCheckFlag} = 4'hf;
      {machineCheckEnable, fpStateClear, machineError, machineErrPtrTied} = 4'h8;
      currentPrivilegeLevel = exc_pkg::PRIV_USER;
      machineErrPtr = 48'h0000_0000_7000;
      dispatchReady = 1'b1;
      ptr = 48'h0001_0000_0000;
      fexp = mk(exc_pkg::VEC_FLOAT, 1'b0, 1'b0);
      aexp = mk(exc_pkg::VEC_ALIGN, 1'b1, 1'b0);
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      #1 chk(64'({dispatchValid, issueStall, shutdown}), 64'h0, "reset");
      // Deferred float error: only waiting forms deliver it.
      i_pipe.report(6'h04, 6'h00, 48'h0000_0000_0aa0);
      run(exc_pkg::FI_NOWAIT, '0, 1'b0, fexp);
      run(exc_pkg::FI_NONE, '0, 1'b0, fexp);
      chk(64'(fpuStatusFlags), 64'h04, "flags");
      chk(64'(fpuInstrPtr), 64'h0aa0, "float pointer");
      run(exc_pkg::FI_WAITING, '0, 1'b1, fexp);
      i_pipe.report(6'h01, 6'h01, 48'h0000_0000_0bb0);
      run(exc_pkg::FI_WAITING, '0, 1'b0, fexp);
      chk(64'(fpuStatusFlags), 64'h05, "masked flags");
      @(posedge clock);
      numericErrorEnable <= 1'b0;
      i_pipe.report(6'h02, 6'h00, 48'h0000_0000_0cc0);
      run(exc_pkg::FI_WAITING, '0, 1'b0, fexp);
      @(posedge clock);
      numericErrorEnable <= 1'b1;
      i_pipe.report(6'h08, 6'h00, 48'h0000_0000_0dd0);
      fpStateClear <= 1'b1;
      @(posedge clock);
      fpStateClear <= 1'b0;
      #1 chk(64'(fpuStatusFlags), 64'h0, "cleared");
      run(exc_pkg::FI_WAITING, '0, 1'b0, fexp);
      // A clear in the cycle of a new error must lose to the error.
      fpStateClear <= 1'b1;
      i_pipe.report(6'h10, 6'h00, 48'h0000_0000_0ee0);
      fpStateClear <= 1'b0;
      #1 chk(64'(fpuStatusFlags), 64'h10, "set wins");
      @(posedge clock);
      dispatchReady <= 1'b0;
      run(exc_pkg::FI_WAITINSN, '0, 1'b1, fexp);
      // Alignment: half the divisor faults, the divisor itself does not.
      for (int c = 1; c < 14; c++) begin
         for (int s = 0; s < 2; s++) begin
            d = div(exc_pkg::opclass_e'(c), s[0]);
            r = mref(exc_pkg::opclass_e'(c), s[0], 32'h0000_1000 + 32'(d / 2));
            run(exc_pkg::FI_NONE, r, 1'b1, aexp);
            r.addr = 32'h0000_1000 + 32'(d);
            run(exc_pkg::FI_NONE, r, 1'b0, aexp);
         end
      end
      run(exc_pkg::FI_NONE, mref(exc_pkg::OP_BYTE, 1'b1, 32'h0000_1001), 1'b0, aexp);
      for (int i = 0; i < 6; i++) begin
         r = mref(exc_pkg::OP_DWORD, 1'b1, 32'h0000_1002);
         r.dataSeg = (i != 3);
         r.implicitSys = (i == 4);
         @(posedge clock);
         alignMaskEnable <= (i != 0);
         alignCheckFlag <= (i != 1);
         currentPrivilegeLevel <= (i == 2) ? 2'h2 : (i == 5) ? 2'h0 : 2'h3;
         run(exc_pkg::FI_NONE, r, 1'b0, aexp);
      end
      @(posedge clock);
      {alignMaskEnable, alignCheckFlag, currentPrivilegeLevel} <= 4'hf;
      // Machine check as abort, then nothing more is accepted.
      @(posedge clock);
      machineErrPtrTied <= 1'b1;
      machineError <= 1'b1;
      @(posedge clock);
      machineError <= 1'b0;
      #1 chk(64'(dispatchValid), 64'h1, "abort");
      fexp = mk(exc_pkg::VEC_MCHK, 1'b0, 1'b1);
      fexp.savedPtr = machineErrPtr;
      chkReq(fexp);
      chk(64'(savedPointerValid), 64'h1, "pointer valid");
      r = mref(exc_pkg::OP_DWORD, 1'b1, 32'h0000_1002);
      run(exc_pkg::FI_NONE, r, 1'b0, aexp);
      // Machine check with checking disabled enters shutdown.
      doReset();
      machineCheckEnable <= 1'b0;
      machineError <= 1'b1;
      @(posedge clock);
      machineError <= 1'b0;
      #1 chk(64'(dispatchValid), 64'h0, "no request");
      chk(64'(shutdown), 64'h1, "shutdown");
      repeat (3) @(posedge clock);
      #1 chk(64'(shutdown), 64'h1, "shutdown held");
      end_of_test();
   end
endmodule : exception_unit_tb
